// ===== sps_defs.svh
/*
  Offsets, field positions and reset values of the serial port block.
  Assumes inclusion by bare name from the design modules and the bench.
*/
`ifndef SPS_DEFS_SVH
`define SPS_DEFS_SVH

`define SPS_OFS_CTRL1      8'h00
`define SPS_OFS_RATE       8'h04
`define SPS_OFS_STATUS     8'h08
`define SPS_OFS_DATA       8'h0C
`define SPS_OFS_PORT       8'h10
`define SPS_OFS_DIR        8'h14
`define SPS_OFS_PUD        8'h18

`define SPS_C1_IE          7
`define SPS_C1_SPE         6
`define SPS_C1_MASTER_SELECT        4
`define SPS_C1_CPOL        3
`define SPS_C1_CPHA        2
`define SPS_C1_SELECT_OUTPUT_ENABLE        1
`define SPS_C1_LSBF        0

`define SPS_ST_TCF         7
`define SPS_ST_WRITE_COLLISION_FLAG        6
`define SPS_ST_MODE_FAULT_FLAG        4

`define SPS_PUD_RD0        4

`define SPS_PIN_RXD        0
`define SPS_PIN_TXD        1
`define SPS_PIN_MISO       4
`define SPS_PIN_MOSI       5
`define SPS_PIN_SCK        6
`define SPS_PIN_SS         7

`define SPS_CTRL1_RST      8'h00
`define SPS_RATE_RST       3'h0
`define SPS_PUD_RST        8'h00
`define SPS_DIR_RST        8'h00
`define SPS_EDGES_LAST     5'hF

`endif

// ===== sps_pkg.sv
/*
  Types shared by the serial port block.
  Assumes nothing beyond the constants header.
*/
package sps_pkg;
  typedef enum logic {
    SPS_IDLE,
    SPS_RUN
  } sps_state_e;
endpackage

// ===== sps_if.sv
/*
  Link between the register side and the serial shift engine.
  Assumes both ends run on the same clock.
*/
interface sps_if;
  logic       load;
  logic [7:0] wdata;
  logic       master;
  logic       cpol;
  logic       cpha;
  logic       lsbf;
  logic [2:0] code;
  logic       miso;
  logic       mosi_in;
  logic       sck_in;
  logic       ss_n;
  logic       busy;
  logic       done;
  logic [7:0] rdata;
  logic       sck;
  logic       sdo;
  modport eng (input load, wdata, master, cpol, cpha, lsbf, code, miso, mosi_in, sck_in, ss_n,
               output busy, done, rdata, sck, sdo);
  modport ctl (output load, wdata, master, cpol, cpha, lsbf, code, miso, mosi_in, sck_in, ss_n,
               input busy, done, rdata, sck, sdo);
endinterface

// ===== sps_shifter.sv
/*
  Serial shift engine: clock divider, eight-bit shifter, receive buffer.
  Assumes pin levels arrive synchronous to core_clk.
*/
`include "sps_defs.svh"
module sps_shifter
  import sps_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  sps_if.eng       bus
);
  sps_state_e st_ff, nxt_st;
  logic [7:0] sh_ff, nxt_sh;
  logic [7:0] rx_ff, nxt_rx;
  logic [7:0] cnt_ff, nxt_cnt;
  logic [4:0] edg_ff, nxt_edg;
  logic       sck_ff, nxt_sck;
  logic       out_ff, nxt_out;
  logic       cap_ff, nxt_cap;
  logic       prv_ff, nxt_prv;
  logic       done_ff, nxt_done;
  logic       ev;
  logic       din;

  function automatic logic [7:0] half_m1(input logic [2:0] code);
    half_m1 = 8'((9'h001 << code) - 9'h001);
  endfunction

  function automatic logic first_bit(input logic [7:0] sh, input logic lsbf);
    first_bit = lsbf ? sh[0] : sh[7];
  endfunction

  always_comb begin
    nxt_st   = st_ff;
    nxt_sh   = sh_ff;
    nxt_rx   = rx_ff;
    nxt_cnt  = 8'h00;
    nxt_edg  = edg_ff;
    nxt_sck  = sck_ff;
    nxt_out  = out_ff;
    nxt_cap  = cap_ff;
    nxt_prv  = bus.sck_in;
    nxt_done = 1'b0;
    din      = bus.master ? bus.miso : bus.mosi_in;
    if (bus.master) begin
      ev = (st_ff == SPS_RUN) && (cnt_ff == half_m1(bus.code));
      if ((st_ff == SPS_RUN) && !ev) begin
        nxt_cnt = cnt_ff + 8'h01;
      end
    end else begin
      ev = !bus.ss_n && (bus.sck_in != prv_ff);
    end
    if (st_ff == SPS_IDLE && bus.master) begin
      nxt_sck = bus.cpol;
    end
    if (bus.load) begin
      nxt_sh  = bus.wdata;
      nxt_edg = 5'h00;
      nxt_out = first_bit(bus.wdata, bus.lsbf);
      if (bus.master) begin
        nxt_st = SPS_RUN;
      end
    end else if (ev) begin
      nxt_st  = SPS_RUN;
      nxt_edg = edg_ff + 5'h01;
      if (bus.master) begin
        nxt_sck = ~sck_ff;
      end
      if (!edg_ff[0]) begin
        if (bus.cpha) begin
          nxt_out = first_bit(sh_ff, bus.lsbf);
        end else begin
          nxt_cap = din;
        end
      end else begin
        nxt_sh = bus.lsbf ? {(bus.cpha ? din : cap_ff), sh_ff[7:1]}
                          : {sh_ff[6:0], (bus.cpha ? din : cap_ff)};
        if (!bus.cpha) begin
          nxt_out = first_bit(nxt_sh, bus.lsbf);
        end
        if (edg_ff == `SPS_EDGES_LAST) begin
          nxt_done = 1'b1;
          nxt_rx   = nxt_sh;
          nxt_st   = SPS_IDLE;
          nxt_edg  = 5'h00;
        end
      end
    end else if (!bus.master && bus.ss_n) begin
      nxt_st  = SPS_IDLE;
      nxt_edg = 5'h00;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff   <= SPS_IDLE;
      sh_ff   <= 8'h00;
      rx_ff   <= 8'h00;
      cnt_ff  <= 8'h00;
      edg_ff  <= 5'h00;
      sck_ff  <= 1'b0;
      out_ff  <= 1'b0;
      cap_ff  <= 1'b0;
      prv_ff  <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      sh_ff   <= nxt_sh;
      rx_ff   <= nxt_rx;
      cnt_ff  <= nxt_cnt;
      edg_ff  <= nxt_edg;
      sck_ff  <= nxt_sck;
      out_ff  <= nxt_out;
      cap_ff  <= nxt_cap;
      prv_ff  <= nxt_prv;
      done_ff <= nxt_done;
    end
  end

  assign bus.busy  = (st_ff == SPS_RUN);
  assign bus.done  = done_ff;
  assign bus.rdata = rx_ff;
  assign bus.sck   = sck_ff;
  assign bus.sdo   = out_ff;

  property p_half_period;
    @(posedge core_clk) disable iff (!rst_n)
      (st_ff == SPS_RUN) && bus.master |-> cnt_ff <= half_m1(bus.code);
  endproperty
  a_half_period: assert property (p_half_period) else $error("Divider count overran.");

  property p_eight_bits;
    @(posedge core_clk) disable iff (!rst_n)
      nxt_done |-> edg_ff == `SPS_EDGES_LAST && edg_ff[0];
  endproperty
  a_eight_bits: assert property (p_eight_bits) else $error("Byte ended early.");
endmodule

// ===== sps_top.sv
/*
  Serial port block: SPI control, status and data registers with the port pin logic.
  Assumes a classic Wishbone master and pin levels synchronous to core_clk.
*/
// How it works
// - Clock pin drives only in master mode with pin 6 direction set.
// - Select pin drives only in master mode with output enable and direction 7.
// - Divider field resets to bus clock over two.
// - Divider code n gives bus clock over two to the power n plus one.
// - Status writes change nothing; status reads always allowed.
// - Done flag sets after eighth clock; cleared by status read then data access.
// - Data write during a transfer is dropped and sets collision flag, no interrupt.
// - Collision flag cleared by status read then data access.
// - Mode fault sets when master and select input is low.
// - Direction bit 7 set inhibits mode fault and keeps flag clear.
// - Mode fault cleared by status read then control one write.
// - Data reads return buffered received byte; writes load the shifter.
// - Master and slave shift eight positions, exchanging bytes.
// - Reset makes every pin an input with direction cleared.
// - Port read gives pin level for inputs, driver value for outputs.
// - Port writes update latch; drive only general outputs.
// - Direction bit 0 means input, 1 output, unless a serial function overrides.
// - UART two-wire receive forces pin 0 to input.
// - UART two-wire transmit forces pin 1 to output.
// - Enabled SPI forces its inputs; its outputs need direction bits set.
// - Slave mode makes pin 7 select input; master mode uses its direction bit.
// - One pull-up and one drive bit per group, three groups; pull-up off on outputs.
// - With interrupt enable, done or mode fault requests an interrupt.
// - System enable reads zero while mode fault is set.
// - Master-select 0 is slave, 1 master.
`include "sps_defs.svh"
module sps_top
  import sps_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  input  wire logic [7:0]  pin_in,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe,
  output logic      [7:0]  pin_pullup,
  output logic      [7:0]  pin_reduced_drive,
  input  wire logic        uart_rx_2wire,
  input  wire logic        uart_tx_2wire,
  input  wire logic        uart_txd
);
  sps_if bus ();

  logic [7:0]  ctl_ff, nxt_ctl;
  logic [2:0]  rate_ff, nxt_rate;
  logic        tcf_ff, nxt_tcf, write_collision_flag_ff, nxt_write_collision_flag, mode_fault_flag_ff, nxt_mode_fault_flag;
  logic        arm_t_ff, nxt_arm_t, arm_w_ff, nxt_arm_w, arm_m_ff, nxt_arm_m;
  logic [7:0]  port_ff, nxt_port, dir_ff, nxt_dir, pud_ff, nxt_pud;
  logic        ack_ff, nxt_ack, irq_ff, nxt_irq;
  logic [31:0] dat_ff, nxt_dat;
  logic [7:0]  po_ff, nxt_po, oe_ff, nxt_oe, pu_ff, nxt_pu, rd_ff, nxt_rd;
  logic        rate_wr_ff, nxt_rate_wr;
  logic        acc, wr, rd, lane0, data_acc, wr_data, wr_c1, rd_stat, rd_c1, fault;
  logic [7:0]  rdv;
  logic        system_enable_bit, master_select;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr == ofs);
  endfunction

  function automatic logic [1:0] group_of(input int i);
    group_of = (i >= 4) ? 2'h2 : ((i >= 2) ? 2'h1 : 2'h0);
  endfunction

  assign system_enable_bit  = ctl_ff[`SPS_C1_SPE];
  assign master_select = ctl_ff[`SPS_C1_MASTER_SELECT];

  always_comb begin
    acc      = wb_cyc_i && wb_stb_i && !ack_ff;
    lane0    = wb_sel_i[0];
    wr       = acc && wb_we_i && lane0;
    rd       = acc && !wb_we_i;
    data_acc = acc && hit(wb_adr_i, `SPS_OFS_DATA);
    wr_data  = wr && hit(wb_adr_i, `SPS_OFS_DATA);
    wr_c1    = wr && hit(wb_adr_i, `SPS_OFS_CTRL1);
    rd_stat  = rd && hit(wb_adr_i, `SPS_OFS_STATUS);
    rd_c1    = rd && hit(wb_adr_i, `SPS_OFS_CTRL1);
    fault    = system_enable_bit && master_select && !dir_ff[`SPS_PIN_SS] && !pin_in[`SPS_PIN_SS];
  end

  always_comb begin
    bus.load    = wr_data && !bus.busy;
    bus.wdata   = wb_dat_i[7:0];
    bus.master  = master_select;
    bus.cpol    = ctl_ff[`SPS_C1_CPOL];
    bus.cpha    = ctl_ff[`SPS_C1_CPHA];
    bus.lsbf    = ctl_ff[`SPS_C1_LSBF];
    bus.code    = rate_ff;
    bus.miso    = pin_in[`SPS_PIN_MISO];
    bus.mosi_in = pin_in[`SPS_PIN_MOSI];
    bus.sck_in  = pin_in[`SPS_PIN_SCK];
    bus.ss_n    = pin_in[`SPS_PIN_SS] || !system_enable_bit;
  end

  sps_shifter u_shifter (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .bus      (bus)
  );

  always_comb begin
    nxt_ctl     = ctl_ff;
    nxt_rate    = rate_ff;
    nxt_port    = port_ff;
    nxt_dir     = dir_ff;
    nxt_pud     = pud_ff;
    nxt_rate_wr = rate_wr_ff;
    nxt_arm_t   = arm_t_ff;
    nxt_arm_w   = arm_w_ff;
    nxt_arm_m   = arm_m_ff;
    nxt_tcf     = tcf_ff;
    nxt_write_collision_flag    = write_collision_flag_ff;
    nxt_mode_fault_flag    = mode_fault_flag_ff;
    if (wr && hit(wb_adr_i, `SPS_OFS_CTRL1)) begin
      nxt_ctl = wb_dat_i[7:0];
    end
    if (wr && hit(wb_adr_i, `SPS_OFS_RATE)) begin
      nxt_rate    = wb_dat_i[2:0];
      nxt_rate_wr = 1'b1;
    end
    if (wr && hit(wb_adr_i, `SPS_OFS_PORT)) begin
      nxt_port = wb_dat_i[7:0];
    end
    if (wr && hit(wb_adr_i, `SPS_OFS_DIR)) begin
      nxt_dir = wb_dat_i[7:0];
    end
    if (wr && hit(wb_adr_i, `SPS_OFS_PUD)) begin
      nxt_pud = wb_dat_i[7:0];
    end
    if (data_acc && arm_t_ff) begin
      nxt_tcf   = 1'b0;
      nxt_arm_t = 1'b0;
    end
    if (data_acc && arm_w_ff) begin
      nxt_write_collision_flag  = 1'b0;
      nxt_arm_w = 1'b0;
    end
    if (wr_c1 && arm_m_ff) begin
      nxt_mode_fault_flag  = 1'b0;
      nxt_arm_m = 1'b0;
    end
    if (rd_stat) begin
      nxt_arm_t = tcf_ff;
      nxt_arm_w = write_collision_flag_ff;
      nxt_arm_m = mode_fault_flag_ff;
    end
    if (bus.done) begin
      nxt_tcf = 1'b1;
    end
    if (wr_data && bus.busy) begin
      nxt_write_collision_flag = 1'b1;
    end
    if (fault) begin
      nxt_mode_fault_flag = 1'b1;
    end
    if (dir_ff[`SPS_PIN_SS]) begin
      nxt_mode_fault_flag  = 1'b0;
      nxt_arm_m = 1'b0;
    end
  end

  always_comb begin
    case (wb_adr_i)
      `SPS_OFS_CTRL1: begin
        rdv = ctl_ff;
        rdv[`SPS_C1_SPE] = system_enable_bit && !mode_fault_flag_ff;
      end
      `SPS_OFS_RATE:   rdv = {5'h00, rate_ff};
      `SPS_OFS_STATUS: begin
        rdv = 8'h00;
        rdv[`SPS_ST_TCF]  = tcf_ff;
        rdv[`SPS_ST_WRITE_COLLISION_FLAG] = write_collision_flag_ff;
        rdv[`SPS_ST_MODE_FAULT_FLAG] = mode_fault_flag_ff;
      end
      `SPS_OFS_DATA:   rdv = bus.rdata;
      `SPS_OFS_PORT:   rdv = (oe_ff & po_ff) | (~oe_ff & pin_in);
      `SPS_OFS_DIR:    rdv = dir_ff;
      `SPS_OFS_PUD:    rdv = pud_ff;
      default:         rdv = 8'h00;
    endcase
    nxt_ack = acc;
    nxt_dat = rd ? {24'h000000, rdv} : 32'h00000000;
    nxt_irq = ctl_ff[`SPS_C1_IE] && (nxt_tcf || nxt_mode_fault_flag);
  end

  always_comb begin
    nxt_oe = dir_ff;
    nxt_po = port_ff;
    if (uart_rx_2wire) begin
      nxt_oe[`SPS_PIN_RXD] = 1'b0;
    end
    if (uart_tx_2wire) begin
      nxt_oe[`SPS_PIN_TXD] = 1'b1;
      nxt_po[`SPS_PIN_TXD] = uart_txd;
    end
    if (system_enable_bit && master_select) begin
      nxt_oe[`SPS_PIN_MISO] = 1'b0;
      nxt_po[`SPS_PIN_MOSI] = bus.sdo;
      nxt_po[`SPS_PIN_SCK]  = bus.sck;
      if (dir_ff[`SPS_PIN_SS] && ctl_ff[`SPS_C1_SELECT_OUTPUT_ENABLE]) begin
        nxt_po[`SPS_PIN_SS] = !bus.busy;
      end
    end else if (system_enable_bit) begin
      nxt_oe[`SPS_PIN_MISO] = dir_ff[`SPS_PIN_MISO] && !pin_in[`SPS_PIN_SS];
      nxt_po[`SPS_PIN_MISO] = bus.sdo;
      nxt_oe[`SPS_PIN_MOSI] = 1'b0;
      nxt_oe[`SPS_PIN_SCK]  = 1'b0;
      nxt_oe[`SPS_PIN_SS]   = 1'b0;
    end
    for (int i = 0; i < 8; i++) begin
      nxt_pu[i] = pud_ff[group_of(i)] && !nxt_oe[i];
      nxt_rd[i] = pud_ff[`SPS_PUD_RD0 + int'(group_of(i))];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_ff     <= `SPS_CTRL1_RST;
      rate_ff    <= `SPS_RATE_RST;
      tcf_ff     <= 1'b0;
      write_collision_flag_ff    <= 1'b0;
      mode_fault_flag_ff    <= 1'b0;
      arm_t_ff   <= 1'b0;
      arm_w_ff   <= 1'b0;
      arm_m_ff   <= 1'b0;
      port_ff    <= 8'h00;
      dir_ff     <= `SPS_DIR_RST;
      pud_ff     <= `SPS_PUD_RST;
      rate_wr_ff <= 1'b0;
      ack_ff     <= 1'b0;
      dat_ff     <= 32'h00000000;
      irq_ff     <= 1'b0;
      po_ff      <= 8'h00;
      oe_ff      <= 8'h00;
      pu_ff      <= 8'h00;
      rd_ff      <= 8'h00;
    end else begin
      ctl_ff     <= nxt_ctl;
      rate_ff    <= nxt_rate;
      tcf_ff     <= nxt_tcf;
      write_collision_flag_ff    <= nxt_write_collision_flag;
      mode_fault_flag_ff    <= nxt_mode_fault_flag;
      arm_t_ff   <= nxt_arm_t;
      arm_w_ff   <= nxt_arm_w;
      arm_m_ff   <= nxt_arm_m;
      port_ff    <= nxt_port;
      dir_ff     <= nxt_dir;
      pud_ff     <= nxt_pud;
      rate_wr_ff <= nxt_rate_wr;
      ack_ff     <= nxt_ack;
      dat_ff     <= nxt_dat;
      irq_ff     <= nxt_irq;
      po_ff      <= nxt_po;
      oe_ff      <= nxt_oe;
      pu_ff      <= nxt_pu;
      rd_ff      <= nxt_rd;
    end
  end

  assign wb_ack_o          = ack_ff;
  assign wb_dat_o          = dat_ff;
  assign irq_o             = irq_ff;
  assign pin_out           = po_ff;
  assign pin_oe            = oe_ff;
  assign pin_pullup        = pu_ff;
  assign pin_reduced_drive = rd_ff;

  property p_sck_oe;
    @(posedge core_clk) disable iff (!rst_n)
      pin_oe[`SPS_PIN_SCK] && $past(system_enable_bit) |-> $past(master_select && dir_ff[`SPS_PIN_SCK]);
  endproperty
  a_sck_oe: assert property (p_sck_oe) else $error("Clock pin driven wrongly.");

  property p_ss_oe;
    @(posedge core_clk) disable iff (!rst_n)
      $past(system_enable_bit && !master_select) |-> !pin_oe[`SPS_PIN_SS];
  endproperty
  a_ss_oe: assert property (p_ss_oe) else $error("Select pin driven in slave mode.");

  property p_rate_rst;
    @(posedge core_clk) disable iff (!rst_n)
      !rate_wr_ff |-> rate_ff == 3'h0;
  endproperty
  a_rate_rst: assert property (p_rate_rst) else $error("Divider not at reset value.");

  property p_stat_wr;
    @(posedge core_clk) disable iff (!rst_n)
      wr && hit(wb_adr_i, `SPS_OFS_STATUS) && !bus.done && !fault |=> tcf_ff == $past(tcf_ff);
  endproperty
  a_stat_wr: assert property (p_stat_wr) else $error("Status write changed a flag.");

  property p_tcf_set;
    @(posedge core_clk) disable iff (!rst_n)
      bus.done |=> tcf_ff;
  endproperty
  a_tcf_set: assert property (p_tcf_set) else $error("Done flag missed.");

  property p_write_collision_flag;
    @(posedge core_clk) disable iff (!rst_n)
      wr_data && bus.busy |-> !bus.load ##1 write_collision_flag_ff;
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("Collision not handled.");

  property p_mode_fault_flag_set;
    @(posedge core_clk) disable iff (!rst_n)
      fault |=> mode_fault_flag_ff;
  endproperty
  a_mode_fault_flag_set: assert property (p_mode_fault_flag_set) else $error("Mode fault missed.");

  property p_mode_fault_flag_inh;
    @(posedge core_clk) disable iff (!rst_n)
      dir_ff[`SPS_PIN_SS] |=> !mode_fault_flag_ff;
  endproperty
  a_mode_fault_flag_inh: assert property (p_mode_fault_flag_inh) else $error("Mode fault not inhibited.");

  property p_irq;
    @(posedge core_clk) disable iff (!rst_n)
      $past(ctl_ff[`SPS_C1_IE]) && $rose(tcf_ff) |-> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt not requested.");

  property p_spe_rb;
    @(posedge core_clk) disable iff (!rst_n)
      rd_c1 && mode_fault_flag_ff |=> !wb_dat_o[`SPS_C1_SPE];
  endproperty
  a_spe_rb: assert property (p_spe_rb) else $error("Enable read back during fault.");
endmodule

// ===== sps_slave_model.sv
/*
  Behavioural SPI slave for the serial port bench: clock format 0, MSB first.
  Assumes pin levels synchronous to core_clk and a master that idles the clock low.
*/
module sps_slave_model (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic      [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh_ff;
  logic       sck_ff;
  logic       sel_ff;
  logic       last_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_ff <= 8'h00;
      rx_byte <= 8'h00;
      sck_ff <= 1'b0;
      sel_ff <= 1'b1;
      last_ff <= 1'b0;
    end else begin
      sck_ff <= sck;
      sel_ff <= sel_n;
      if (sel_ff && !sel_n) begin
        sh_ff <= tx_byte;
      end else if (!sel_n && sck && !sck_ff) begin
        rx_byte <= {rx_byte[6:0], mosi};
      end else if (!sel_n && !sck && sck_ff) begin
        sh_ff <= {sh_ff[6:0], 1'b0};
      end
      if (!sel_n) begin
        last_ff <= sh_ff[7];
      end
    end
  end
  // A released line shows the inverse of its last level.
  assign miso = sel_n ? ~last_ff : sh_ff[7];
endmodule

// ===== test_spi_port_s_control.sv
/*
  Self-checking bench for the serial port block over classic Wishbone.
  Assumes the slave model on the SPI pins and a 25 MHz core_clk.
*/
`include "sps_defs.svh"
module test_spi_port_s_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] A_C1 = `SPS_OFS_CTRL1;
  localparam logic [7:0] A_RT = `SPS_OFS_RATE;
  localparam logic [7:0] A_ST = `SPS_OFS_STATUS;
  localparam logic [7:0] A_DT = `SPS_OFS_DATA;
  localparam logic [7:0] A_PT = `SPS_OFS_PORT;
  localparam logic [7:0] A_DR = `SPS_OFS_DIR;
  localparam logic [7:0] A_PU = `SPS_OFS_PUD;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        irq;
  logic [7:0]  pin_in;
  logic [7:0]  pin_out;
  logic [7:0]  pin_oe;
  logic [7:0]  pin_pu;
  logic [7:0]  pin_rd;
  logic        u_rx = 1'b0;
  logic        u_tx = 1'b0;
  logic        u_txd = 1'b0;
  logic [7:0]  ext = 8'h9A;
  logic [7:0]  s_tx = 8'hA6;
  logic [7:0]  s_rx;
  logic        s_miso;
  logic [7:0]  q;
  int          failures = 0;
  int          n_checks = 0;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & {ext[7:5], s_miso, ext[3:0]});
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  sps_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq_o(irq), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pu), .pin_reduced_drive(pin_rd), .uart_rx_2wire(u_rx),
    .uart_tx_2wire(u_tx), .uart_txd(u_txd));
  sps_slave_model slv_u (.core_clk(core_clk), .rst_n(rst_n), .sck(pin_in[6]),
    .mosi(pin_in[5]), .sel_n(pin_in[7]), .tx_byte(s_tx), .miso(s_miso), .rx_byte(s_rx));
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
    n_checks++;
    if (s !== e) begin
      $display("ERROR %0t %s: seen %h expected %h", $time, m, s, e);
      failures++;
    end
  endtask
  task automatic bail(input string m);
    $display("ERROR %0t timeout %s", $time, m);
    failures++;
    wrap_up();
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge core_clk);
    if (i == 20) bail("bus");
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wait_sck(input logic v, output int n);
    for (n = 0; n < 600 && pin_out[6] !== v; n++) @(posedge core_clk);
    if (n == 600) bail("sck");
  endtask
  task automatic wait_done();
    int i;
    for (i = 0; i < 3000; i++) begin
      wb(0, A_ST, 8'h00);
      if (q[7] === 1'b1) break;
    end
    if (i == 3000) bail("done");
  endtask
  task automatic t_reset();
    wb(0, A_RT, 8'h00);
    chk(q, 8'h00, "rate reset");
    wb(0, A_DR, 8'h00);
    chk(q, 8'h00, "dir reset");
    chk(pin_oe, 8'h00, "oe reset");
    wb(0, 8'h1C, 8'h00);
    chk(q, 8'h00, "unmapped");
  endtask
  task automatic t_port();
    wb(1, A_DR, 8'h0C);
    wb(1, A_PT, 8'hA5);
    wb(1, A_PU, 8'h17);
    idle(3);
    chk(pin_oe, 8'h0C, "oe");
    chk(pin_out & 8'h0C, 8'h04, "out");
    chk(pin_pu, 8'hF3, "pullup");
    chk(pin_rd, 8'h03, "drive");
    wb(0, A_PT, 8'h00);
    chk(q, 8'h96, "port read");
    wb(1, A_DR, 8'h01);
    u_rx <= 1'b1;
    u_tx <= 1'b1;
    u_txd <= 1'b1;
    idle(3);
    chk(pin_oe[1:0], 2'b10, "uart dir");
    chk(pin_out[1], 1'b1, "uart txd");
    u_rx <= 1'b0;
    u_tx <= 1'b0;
  endtask
  task automatic t_rates();
    int n;
    wb(1, A_DR, 8'hE0);
    wb(1, A_PT, 8'h40);
    wb(1, A_C1, 8'h52);
    idle(3);
    chk(pin_out[6], 1'b0, "latch kept off sck");
    chk(pin_oe[7:4], 4'hE, "spi oe");
    for (int k = 0; k < 8; k++) begin
      wb(1, A_RT, k[7:0]);
      wb(1, A_DT, 8'h81);
      wait_sck(1'b1, n);
      chk(pin_out[7], 1'b0, "select low");
      wait_sck(1'b0, n);
      chk(n, 1 << k, "half period");
      wait_done();
      chk(pin_out[7], 1'b1, "select idle");
      wb(1, A_ST, 8'h00);
      wb(0, A_ST, 8'h00);
      chk(q, 8'h80, "status write");
      wb(0, A_DT, 8'h00);
      wb(0, A_ST, 8'h00);
      chk(q, 8'h00, "done clear");
    end
  endtask
  task automatic t_xchg();
    wb(1, A_C1, 8'hD2);
    wb(1, A_RT, 8'h03);
    wb(1, A_DT, 8'h3C);
    wb(1, A_DT, 8'h55);
    chk(irq, 1'b0, "no irq on collision");
    wait_done();
    wb(0, A_ST, 8'h00);
    chk(q, 8'hC0, "done and collision");
    chk(irq, 1'b1, "irq");
    wb(0, A_DT, 8'h00);
    chk(q, 8'hA6, "rx byte");
    chk(s_rx, 8'h3C, "slave rx");
    wb(0, A_ST, 8'h00);
    chk(q, 8'h00, "flags clear");
  endtask
  task automatic t_modes();
    wb(1, A_C1, 8'h53);
    wb(1, A_DT, 8'h1E);
    wait_done();
    wb(0, A_DT, 8'h00);
    chk(q, 8'h65, "lsb first rx");
    chk(s_rx, 8'h78, "lsb first tx");
    wb(0, A_ST, 8'h00);
    chk(q, 8'h00, "lsb first flags clear");
  endtask
  task automatic t_fault();
    wb(1, A_C1, 8'h00);
    wb(1, A_DR, 8'h60);
    ext[7] <= 1'b0;
    wb(1, A_C1, 8'hD0);
    idle(3);
    wb(0, A_ST, 8'h00);
    chk(q & 8'h10, 8'h10, "mode fault");
    wb(0, A_C1, 8'h00);
    chk(q[6], 1'b0, "enable reads 0");
    chk(irq, 1'b1, "fault irq");
    ext[7] <= 1'b1;
    idle(3);
    wb(0, A_ST, 8'h00);
    wb(1, A_C1, 8'h50);
    wb(0, A_ST, 8'h00);
    chk(q, 8'h00, "fault clear");
    wb(1, A_DR, 8'hE0);
    ext[7] <= 1'b0;
    idle(3);
    wb(0, A_ST, 8'h00);
    chk(q, 8'h00, "fault inhibited");
    wb(1, A_C1, 8'h40);
    wb(1, A_DR, 8'h80);
    idle(3);
    chk(pin_oe[7], 1'b0, "slave select input");
  endtask
  initial begin
    idle(6);
    rst_n <= 1'b1;
    t_reset();
    t_port();
    t_rates();
    t_xchg();
    t_modes();
    t_fault();
    wrap_up();
  end
endmodule
